// ---- src/frame_decoder_consts.vh ----
// Purpose: Shared constants of the serial write-frame decoder
// Assumes: Included by bare name from the design files
// Notes:   Register offsets are word indices; byte address is 4 x index
`ifndef FRAME_DECODER_CONSTS_VH
`define FRAME_DECODER_CONSTS_VH

// ****************************************************************
// Frame field positions
// ****************************************************************
`define FRM_RW_BIT        23
`define FRM_DEV_HI_BIT    22
`define FRM_DEV_LO_BIT    21
`define FRM_SEL_MSB       20
`define FRM_SEL_LSB       18
`define FRM_CH_MSB        17
`define FRM_CH_LSB        16
`define FRM_DATA_MSB      15
`define FRM_CODE_LSB      4
`define FRM_BITS_PLAIN    6'h18
`define FRM_BITS_CHECKED  6'h20

// ****************************************************************
// Register selector codes
// ****************************************************************
`define SEL_DATA_ONE      3'h0
`define SEL_RESERVED      3'h1
`define SEL_GAIN_ONE      3'h2
`define SEL_GAIN_ALL      3'h3
`define SEL_OFFSET_ONE    3'h4
`define SEL_OFFSET_ALL    3'h5
`define SEL_CLEAR_ONE     3'h6
`define SEL_CONTROL       3'h7

// ****************************************************************
// Reset values of the 12-bit channel codes
// ****************************************************************
`define RST_DATA_CODE     12'h000
`define RST_GAIN_CODE     12'hfff
`define RST_OFFSET_CODE   12'h800

// ****************************************************************
// Bus register word indices
// ****************************************************************
`define REG_CONFIG        4'h0
`define REG_STATUS        4'h1
`define REG_LAST_CTRL     4'h2
`define REG_LAST_READ     4'h3
`define REG_DATA_BASE     2'h1
`define REG_GAIN_BASE     2'h2
`define REG_OFFSET_BASE   2'h3
`define CFG_CHECK_BIT     0

`endif

// ---- src/serial_frame_receiver.v ----
// Purpose: Samples the 3-wire link and collects one frame per select
// Assumes: Link clock far slower than clock_i; data taken on its fall
// Notes:   Frame of wrong length is reported and dropped
`include "frame_decoder_consts.vh"
`default_nettype none

module serial_frame_receiver (
  input  wire        clock_i,
  input  wire        reset_n_i,
  input  wire        link_clk_i,
  input  wire        link_select_n_i,
  input  wire        link_data_i,
  input  wire        check_en_i,
  output reg         frame_ok_o,
  output reg         frame_bad_o,
  output reg  [23:0] frame_o
);

  // ****************************************************************
  // Two-stage synchronisers and edge history
  // ****************************************************************
  reg  [2:0]  sclk_reg;
  reg  [2:0]  sel_reg;
  reg  [1:0]  sdin_reg;
  reg  [31:0] shift_reg;
  reg  [5:0]  count_reg;

  wire sclk_fall  = sclk_reg[2] & ~sclk_reg[1];
  wire sel_active = ~sel_reg[1];
  wire sel_rise   = ~sel_reg[2] & sel_reg[1];
  wire [5:0] want = check_en_i ? `FRM_BITS_CHECKED : `FRM_BITS_PLAIN;

  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sclk_reg <= 3'h7;
      sel_reg  <= 3'h7;
      sdin_reg <= 2'h0;
    end else begin
      sclk_reg <= {sclk_reg[1:0], link_clk_i};
      sel_reg  <= {sel_reg[1:0], link_select_n_i};
      sdin_reg <= {sdin_reg[0], link_data_i};
    end
  end

  // ****************************************************************
  // Shift in, most significant bit first
  // ****************************************************************
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shift_reg   <= 32'h0000_0000;
      count_reg   <= 6'h00;
      frame_ok_o  <= 1'b0;
      frame_bad_o <= 1'b0;
      frame_o     <= 24'h00_0000;
    end else begin
      frame_ok_o  <= 1'b0;
      frame_bad_o <= 1'b0;
      if (sel_rise) begin
        count_reg <= 6'h00;
        if (count_reg == want) begin
          frame_ok_o <= 1'b1;
          frame_o <= check_en_i ? shift_reg[31:8] : shift_reg[23:0];
        end else begin
          frame_bad_o <= 1'b1;
        end
      end else if (sel_active && sclk_fall) begin
        shift_reg <= {shift_reg[30:0], sdin_reg[1]};
        if (count_reg != 6'h3f) begin
          count_reg <= count_reg + 6'h01;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ---- src/dac_write_frame_decoder.v ----
// Purpose: Decodes serial write frames into channel code registers
// Assumes: Straps and link pins are asynchronous to clock_i
// Notes:   Avalon-MM slave, one wait state on every access
//
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`include "frame_decoder_consts.vh"
`default_nettype none

// Functional notes
// - Frame MSB first, fields at fixed bits
// - Channel code is frame bits 15 to 4
// - Top bit zero writes, one reads
// - Act only when address matches strap pins
// - Selector 000 loads one channel data code
// - Selector 010 one gain, 011 all gains
// - Selector 100 one offset, 101 all offsets
// - Selector 111 passes data field, frame bits 15 to 0, to control registers
// - Channel codes 00..11 pick channels A..D
// - Frame is 24 bits, 32 with check
module dac_write_frame_decoder #(
  parameter CHANNELS = 4
) (
  input  wire                  clock_i,
  input  wire                  reset_n_i,
  input  wire                  link_clk_i,
  input  wire                  link_select_n_i,
  input  wire                  link_data_i,
  input  wire                  address_strap_hi_i,
  input  wire                  address_strap_lo_i,
  input  wire [3:0]            avs_address_i,
  input  wire                  avs_read_i,
  input  wire                  avs_write_i,
  input  wire [31:0]           avs_writedata_i,
  input  wire [3:0]            avs_byteenable_i,
  output reg  [31:0]           avs_readdata_o,
  output reg                   avs_waitrequest_o,
  output reg  [12*CHANNELS-1:0] dac_code_o,
  output reg  [12*CHANNELS-1:0] gain_code_o,
  output reg  [12*CHANNELS-1:0] offset_code_o,
  output reg                   ctrl_write_o,
  output reg  [15:0]           ctrl_data_o,
  output reg                   read_request_o,
  output reg  [4:0]            read_target_o,
  output reg                   check_en_o
);

  // ****************************************************************
  // Strap synchronisers
  // ****************************************************************
  reg  [1:0] strap_meta_reg;
  reg  [1:0] strap_reg;

  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      strap_meta_reg <= 2'h0;
      strap_reg      <= 2'h0;
    end else begin
      strap_meta_reg <= {address_strap_hi_i, address_strap_lo_i};
      strap_reg      <= strap_meta_reg;
    end
  end

  // ****************************************************************
  // Frame reception
  // ****************************************************************
  wire        frame_ok;
  wire        frame_bad;
  wire [23:0] frame;

  serial_frame_receiver serial_frame_receiver_i (
    .clock_i         (clock_i),
    .reset_n_i       (reset_n_i),
    .link_clk_i      (link_clk_i),
    .link_select_n_i (link_select_n_i),
    .link_data_i     (link_data_i),
    .check_en_i      (check_en_o),
    .frame_ok_o      (frame_ok),
    .frame_bad_o     (frame_bad),
    .frame_o         (frame)
  );

  // ****************************************************************
  // Field split
  // ****************************************************************
  wire        read_flag = frame[`FRM_RW_BIT];
  wire        target_device_addr_hi = frame[`FRM_DEV_HI_BIT];
  wire        target_device_addr_lo = frame[`FRM_DEV_LO_BIT];
  wire [2:0]  register_selector = frame[`FRM_SEL_MSB:`FRM_SEL_LSB];
  wire        channel_select_hi = frame[`FRM_CH_MSB];
  wire        channel_select_lo = frame[`FRM_CH_LSB];
  wire [1:0]  channel = {channel_select_hi, channel_select_lo};
  wire [15:0] field = frame[`FRM_DATA_MSB:0];
  wire [11:0] code = frame[`FRM_DATA_MSB:`FRM_CODE_LSB];

  wire addr_hit = (target_device_addr_hi == strap_reg[1]) &&
                  (target_device_addr_lo == strap_reg[0]);
  wire accept   = frame_ok && addr_hit;
  wire do_write = accept && !read_flag;
  wire do_read  = accept && read_flag;

  // ****************************************************************
  // Channel code registers
  // ****************************************************************
  wire [12*CHANNELS-1:0] dac_code_next;
  wire [12*CHANNELS-1:0] gain_code_next;
  wire [12*CHANNELS-1:0] offset_code_next;

  // Reserved, clear code and control leave codes alone
  wire live = do_write && (register_selector != `SEL_RESERVED);

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_channel
      wire pick     = ({30'h0000_0000, channel} == ch);
      wire data_hit = live && pick &&
                      (register_selector == `SEL_DATA_ONE);
      wire gain_hit = live &&
                      ((pick && register_selector == `SEL_GAIN_ONE) ||
                       register_selector == `SEL_GAIN_ALL);
      wire offs_hit = live &&
                      ((pick && register_selector == `SEL_OFFSET_ONE) ||
                       register_selector == `SEL_OFFSET_ALL);
      assign dac_code_next[12*ch +: 12] =
        data_hit ? code : dac_code_o[12*ch +: 12];
      assign gain_code_next[12*ch +: 12] =
        gain_hit ? code : gain_code_o[12*ch +: 12];
      assign offset_code_next[12*ch +: 12] =
        offs_hit ? code : offset_code_o[12*ch +: 12];
    end
  endgenerate

  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dac_code_o    <= {CHANNELS{`RST_DATA_CODE}};
      gain_code_o   <= {CHANNELS{`RST_GAIN_CODE}};
      offset_code_o <= {CHANNELS{`RST_OFFSET_CODE}};
    end else begin
      dac_code_o    <= dac_code_next;
      gain_code_o   <= gain_code_next;
      offset_code_o <= offset_code_next;
    end
  end

  // ****************************************************************
  // Control hand-off, read requests, frame statistics
  // ****************************************************************
  reg [7:0] good_count_reg;
  reg [7:0] bad_count_reg;

  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_write_o   <= 1'b0;
      ctrl_data_o    <= 16'h0000;
      read_request_o <= 1'b0;
      read_target_o  <= 5'h00;
      good_count_reg <= 8'h00;
      bad_count_reg  <= 8'h00;
    end else begin
      ctrl_write_o   <= 1'b0;
      read_request_o <= 1'b0;
      if (do_write && register_selector == `SEL_CONTROL) begin
        ctrl_write_o <= 1'b1;
        ctrl_data_o  <= field;
      end
      if (do_read) begin
        read_request_o <= 1'b1;
        read_target_o  <= {register_selector, channel};
      end
      if (accept) begin
        good_count_reg <= good_count_reg + 8'h01;
      end
      if (frame_bad) begin
        bad_count_reg <= bad_count_reg + 8'h01;
      end
    end
  end

  // ****************************************************************
  // Avalon-MM slave, answer one cycle after the request
  // ****************************************************************
  wire       request = (avs_read_i || avs_write_i) && avs_waitrequest_o;
  wire [1:0] bank    = avs_address_i[3:2];
  wire [1:0] lane    = avs_address_i[1:0];
  reg [31:0] read_value;

  always @* begin
    read_value = 32'h0000_0000;
    case (bank)
      `REG_DATA_BASE: begin
        read_value = {16'h0000, dac_code_o[12*lane +: 12], 4'h0};
      end
      `REG_GAIN_BASE: begin
        read_value = {16'h0000, gain_code_o[12*lane +: 12], 4'h0};
      end
      `REG_OFFSET_BASE: begin
        read_value = {16'h0000, offset_code_o[12*lane +: 12], 4'h0};
      end
      default: begin
        case (avs_address_i)
          `REG_CONFIG: begin
            read_value = {31'h0000_0000, check_en_o};
          end
          `REG_STATUS: begin
            read_value = {14'h0000, strap_reg, bad_count_reg,
                          good_count_reg};
          end
          `REG_LAST_CTRL: begin
            read_value = {16'h0000, ctrl_data_o};
          end
          `REG_LAST_READ: begin
            read_value = {27'h000_0000, read_target_o};
          end
          default: begin
            read_value = 32'h0000_0000;
          end
        endcase
      end
    endcase
  end

  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
      check_en_o        <= 1'b0;
    end else begin
      avs_waitrequest_o <= !request;
      if (request && avs_read_i) begin
        avs_readdata_o <= read_value;
      end
      if (request && avs_write_i && avs_address_i == `REG_CONFIG &&
          avs_byteenable_i[0]) begin
        check_en_o <= avs_writedata_i[`CFG_CHECK_BIT];
      end
    end
  end

endmodule

`default_nettype wire

// ---- test/link_host_model.sv ----
// Purpose: Host end of the 3-wire link
// Assumes: Clock idles high; the device takes data on its fall
// Notes:   Data line shows the inverted last bit between frames
`default_nettype none
module link_host_model (
  output logic link_clk_o,
  output logic link_select_n_o,
  output logic link_data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    link_clk_o = 1'b1;
    link_select_n_o = 1'b1;
    link_data_o = 1'b0;
  end
  // ********
  // Frame shift
  // ********
  task automatic send(input logic [31:0] f, input int n);
    #3.1 link_select_n_o = 1'b0;
    for (int i = 31; i > 31 - n; i--) begin
      #40 link_data_o = f[i];
      #40 link_clk_o = 1'b0;
      #80 link_clk_o = 1'b1;
    end
    #40 link_data_o = ~link_data_o;
    link_select_n_o = 1'b1;
    #40;
  endtask
endmodule
`default_nettype wire

// ---- test/dac_write_frame_decoder_sva.sv ----
// Purpose: Assertions on the decoder's bus and code outputs
// Assumes: One clock domain, reset active low
// Notes:   Bound to every decoder instance
`default_nettype none
module dac_write_frame_decoder_sva #(
  parameter CHANNELS = 4
) (
  input wire logic                    clock_i,
  input wire logic                    reset_n_i,
  input wire logic                    avs_read_i,
  input wire logic                    avs_write_i,
  input wire logic                    avs_waitrequest_o,
  input wire logic [12*CHANNELS-1:0]  dac_code_o,
  input wire logic [12*CHANNELS-1:0]  gain_code_o,
  input wire logic [12*CHANNELS-1:0]  offset_code_o,
  input wire logic                    ctrl_write_o,
  input wire logic [15:0]             ctrl_data_o,
  input wire logic                    read_request_o,
  input wire logic [4:0]              read_target_o,
  input wire logic                    check_en_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  function automatic int lanes(input logic [12*CHANNELS-1:0] x);
    lanes = 0;
    for (int i = 0; i < CHANNELS; i++) lanes += int'(|x[12*i +: 12]);
  endfunction
  // ********
  // Properties
  // ********
  property p_wait;
    (avs_read_i || avs_write_i) && avs_waitrequest_o
      |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer late");
  property p_cfg;
    $changed(check_en_o) |-> avs_write_i && !avs_waitrequest_o;
  endproperty
  a_cfg: assert property (p_cfg) else $error("check_en moved");
  property p_dir;
    !(ctrl_write_o && read_request_o);
  endproperty
  a_dir: assert property (p_dir) else $error("read and write");
  property p_rd_quiet;
    read_request_o |-> $stable(dac_code_o) && $stable(gain_code_o);
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read wrote");
  property p_tgt;
    $changed(read_target_o) |-> read_request_o;
  endproperty
  a_tgt: assert property (p_tgt) else $error("target moved");
  property p_ctrl;
    ctrl_write_o |=> !ctrl_write_o;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("ctrl pulse long");
  property p_cdata;
    $changed(ctrl_data_o) |-> ctrl_write_o;
  endproperty
  a_cdata: assert property (p_cdata) else $error("ctrl data moved");
  property p_lane;
    $changed(dac_code_o) |-> lanes(dac_code_o ^ $past(dac_code_o)) == 1;
  endproperty
  a_lane: assert property (p_lane) else $error("many lanes");
  property p_kind;
    $changed(dac_code_o) |-> $stable(gain_code_o) && $stable(offset_code_o);
  endproperty
  a_kind: assert property (p_kind) else $error("two kinds");
endmodule
bind dac_write_frame_decoder dac_write_frame_decoder_sva
  #(.CHANNELS(CHANNELS)) dac_write_frame_decoder_sva_i (
  .clock_i           (clock_i),
  .reset_n_i         (reset_n_i),
  .avs_read_i        (avs_read_i),
  .avs_write_i       (avs_write_i),
  .avs_waitrequest_o (avs_waitrequest_o),
  .dac_code_o        (dac_code_o),
  .gain_code_o       (gain_code_o),
  .offset_code_o     (offset_code_o),
  .ctrl_write_o      (ctrl_write_o),
  .ctrl_data_o       (ctrl_data_o),
  .read_request_o    (read_request_o),
  .read_target_o     (read_target_o),
  .check_en_o        (check_en_o)
);
`default_nettype wire

// ---- test/dac_write_frame_decoder_tb.sv ----
// Purpose: Self-checking bench of the write-frame decoder
// Assumes: Host model shifts frames; tasks speak Avalon-MM
// Notes:   Expected codes kept in local arrays
`include "frame_decoder_consts.vh"
`default_nettype none
module dac_write_frame_decoder_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock_i, reset_n_i, link_clk_i, link_select_n_i;
  logic        link_data_i, address_strap_hi_i, address_strap_lo_i;
  logic [3:0]  avs_address_i, avs_byteenable_i;
  logic        avs_read_i, avs_write_i, avs_waitrequest_o, e_cen;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic [47:0] dac_code_o, gain_code_o, offset_code_o;
  logic        ctrl_write_o, read_request_o, check_en_o;
  logic [15:0] ctrl_data_o, e_ctrl, tv[4];
  logic [4:0]  read_target_o, e_tgt;
  logic [11:0] e_dac[4], e_gain[4], e_off[4];
  int          fails, total_checks, n_cw, n_rr, e_cw, e_rr;
  dac_write_frame_decoder dac_write_frame_decoder_i (
    .clock_i            (clock_i),
    .reset_n_i          (reset_n_i),
    .link_clk_i         (link_clk_i),
    .link_select_n_i    (link_select_n_i),
    .link_data_i        (link_data_i),
    .address_strap_hi_i (address_strap_hi_i),
    .address_strap_lo_i (address_strap_lo_i),
    .avs_address_i      (avs_address_i),
    .avs_read_i         (avs_read_i),
    .avs_write_i        (avs_write_i),
    .avs_writedata_i    (avs_writedata_i),
    .avs_byteenable_i   (avs_byteenable_i),
    .avs_readdata_o     (avs_readdata_o),
    .avs_waitrequest_o  (avs_waitrequest_o),
    .dac_code_o         (dac_code_o),
    .gain_code_o        (gain_code_o),
    .offset_code_o      (offset_code_o),
    .ctrl_write_o       (ctrl_write_o),
    .ctrl_data_o        (ctrl_data_o),
    .read_request_o     (read_request_o),
    .read_target_o      (read_target_o),
    .check_en_o         (check_en_o)
  );
  link_host_model link_host_model_i (.link_clk_o(link_clk_i),
    .link_select_n_o(link_select_n_i), .link_data_o(link_data_i));
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    n_cw += int'(ctrl_write_o === 1'b1);
    n_rr += int'(read_request_o === 1'b1);
  end
  // ********
  // Shared tasks
  // ********
  task automatic check(input logic [47:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !w;
    avs_write_i <= w;
    do begin
      @(posedge clock_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic frame(input logic [2:0] s, input logic [1:0] ch,
    input logic [15:0] d, input logic [1:0] dev, input logic rw, int n);
    link_host_model_i.send({rw, dev, s, ch, d, 8'h5a}, n);
    repeat (8) @(posedge clock_i);
    if (n == (e_cen ? 32 : 24) &&
        dev == {address_strap_hi_i, address_strap_lo_i}) begin
      if (rw) begin
        e_rr++;
        e_tgt = {s, ch};
      end else case (s)
        `SEL_DATA_ONE: e_dac[ch] = d[15:4];
        `SEL_GAIN_ONE: e_gain[ch] = d[15:4];
        `SEL_GAIN_ALL: e_gain = '{4{d[15:4]}};
        `SEL_OFFSET_ONE: e_off[ch] = d[15:4];
        `SEL_OFFSET_ALL: e_off = '{4{d[15:4]}};
        `SEL_CONTROL: begin
          e_cw++;
          e_ctrl = d;
        end
        default: ;
      endcase
    end
    check(dac_code_o, {e_dac[3], e_dac[2], e_dac[1], e_dac[0]});
    check(gain_code_o, {e_gain[3], e_gain[2], e_gain[1], e_gain[0]});
    check(offset_code_o, {e_off[3], e_off[2], e_off[1], e_off[0]});
    check(48'(ctrl_data_o), 48'(e_ctrl));
    check(48'(n_cw), 48'(e_cw));
    check(48'(n_rr), 48'(e_rr));
    check(48'(read_target_o), 48'(e_tgt));
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_single;
    tv = '{16'h000f, 16'hfff0, 16'h5a3c, 16'ha5c7};
    for (int c = 0; c < 4; c++) begin
      frame(`SEL_DATA_ONE, 2'(c), tv[c], 2'b10, 1'b0, 24);
      frame(`SEL_GAIN_ONE, 2'(c), ~tv[c], 2'b10, 1'b0, 24);
      frame(`SEL_OFFSET_ONE, 2'(3 - c), tv[c], 2'b10, 1'b0, 24);
    end
  endtask
  task automatic t_other;
    frame(`SEL_GAIN_ALL, 2'd2, 16'h7ff3, 2'b10, 1'b0, 24);
    frame(`SEL_OFFSET_ALL, 2'd1, 16'h0019, 2'b10, 1'b0, 24);
    frame(`SEL_CLEAR_ONE, 2'd0, 16'h1111, 2'b10, 1'b0, 24);
    frame(`SEL_DATA_ONE, 2'd3, 16'h2222, 2'b10, 1'b1, 24);
    frame(`SEL_CONTROL, 2'd0, 16'hc3a5, 2'b10, 1'b0, 24);
    frame(`SEL_CONTROL, 2'd2, 16'h5c3a, 2'b10, 1'b0, 24);
    for (int v = 0; v < 4; v++)
      frame(`SEL_DATA_ONE, 2'd1, 16'h3333, 2'(v), 1'b0, 24);
  endtask
  task automatic t_check;
    bus(1'b1, `REG_CONFIG, 32'h0000_0001);
    e_cen = 1'b1;
    check(48'(check_en_o), 48'h1);
    frame(`SEL_DATA_ONE, 2'd0, 16'h1234, 2'b10, 1'b0, 32);
    frame(`SEL_DATA_ONE, 2'd0, 16'h4321, 2'b10, 1'b0, 24);
    bus(1'b0, `REG_STATUS, 32'h0);
    check(48'(q[17:0]), 48'h0000_0002_0115);
    bus(1'b0, {`REG_DATA_BASE, 2'd0}, 32'h0);
    check(48'(q), {32'h0, e_dac[0], 4'h0});
    bus(1'b1, `REG_CONFIG, 32'h0);
    e_cen = 1'b0;
    address_strap_lo_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    frame(`SEL_DATA_ONE, 2'd2, 16'h0ab0, 2'b11, 1'b0, 24);
    frame(`SEL_DATA_ONE, 2'd2, 16'h0cd0, 2'b10, 1'b0, 24);
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #600000;
    fails++;
    $display("ERROR %0t: timeout", $time);
    tally_and_finish;
  end
  initial begin
    {reset_n_i, avs_read_i, avs_write_i, address_strap_lo_i} = 4'h0;
    address_strap_hi_i = 1'b1;
    avs_address_i = 4'h0;
    avs_byteenable_i = 4'h1;
    avs_writedata_i = 32'h0;
    {fails, total_checks, n_cw, n_rr, e_cw, e_rr} = '0;
    {e_ctrl, e_tgt, e_cen} = '0;
    e_dac = '{4{`RST_DATA_CODE}};
    e_gain = '{4{`RST_GAIN_CODE}};
    e_off = '{4{`RST_OFFSET_CODE}};
    repeat (10) @(posedge clock_i);
    reset_n_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    frame(`SEL_RESERVED, 2'd1, 16'hffff, 2'b10, 1'b0, 24);
    t_single;
    t_other;
    t_check;
    tally_and_finish;
  end
endmodule
`default_nettype wire
